// File: verilog/uart_mp_pkg.sv
// constants, types and helpers for the multi-drop serial port with address filter
//
// Summary of operation
// - filter on: drop frames lacking address information
// - 5-8 data bits: first stop bit types frame
// - 9 data bits: ninth bit types frame
// - type one is address, zero is data
// - transmitter ignores the filter enable
// - kept address frame sets receive-complete normally
// - filter off accepts data; others keep ignoring
// - one character size serves transmitter and receiver
// - divisor zero gives the highest baud rate
package uart_mp_pkg;

    localparam int          ADDR_W        = 8;
    localparam int          DIV_W         = 12;
    localparam int          CTRL_W        = 9;
    localparam int          EV_W          = 3;

    // register byte offsets
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_DATA     = 8'h08;
    localparam logic [7:0]  ADDR_BAUD     = 8'h0c;
    localparam logic [7:0]  ADDR_INT_STAT = 8'h10;
    localparam logic [7:0]  ADDR_INT_MASK = 8'h14;

    // control register fields
    localparam int          CTRL_FILTER   = 0;   // multiproc_filter_bit
    localparam int          CTRL_SIZE_LSB = 1;   // char_size_select, 3 bits
    localparam int          CTRL_STOP2    = 4;   // stop_bit_count_select
    localparam int          CTRL_DOUBLE   = 5;   // double_speed_select
    localparam int          CTRL_TX9      = 6;   // tx_ninth_bit
    localparam int          CTRL_RXEN     = 7;
    localparam int          CTRL_TXEN     = 8;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

    // status register fields
    localparam int          ST_RXC        = 0;   // rx_complete_flag
    localparam int          ST_TXC        = 1;   // tx_complete_flag
    localparam int          ST_FE         = 2;
    localparam int          ST_RX9        = 3;   // rx_ninth_bit
    localparam int          ST_TXBUSY     = 4;

    // interrupt event bits
    localparam int          EV_RXC        = 0;
    localparam int          EV_TXC        = 1;
    localparam int          EV_FE         = 2;

    localparam logic [2:0]  SIZE_NINE     = 3'h7;
    localparam logic [3:0]  BITS_NINE     = 4'h9;
    localparam logic [3:0]  BITS_MIN      = 4'h5;

    // oversampling: 16 per bit normal, 8 per bit double speed
    localparam logic [3:0]  LAST_NORMAL   = 4'hf;
    localparam logic [3:0]  LAST_DOUBLE   = 4'h7;
    localparam logic [3:0]  HALF_NORMAL   = 4'h7;
    localparam logic [3:0]  HALF_DOUBLE   = 4'h3;

    localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
    localparam logic [EV_W-1:0]  EV_NONE   = 3'h0;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;

    // shared size decode keeps both directions on one setting
    function automatic logic [3:0] dataBits(input logic [2:0] size);
        if (size == SIZE_NINE) begin
            return BITS_NINE;
        end
        return BITS_MIN + {2'b00, size[1:0]};
    endfunction

    function automatic logic [3:0] lastTick(input logic dbl);
        return dbl ? LAST_DOUBLE : LAST_NORMAL;
    endfunction

    function automatic logic [3:0] halfTick(input logic dbl);
        return dbl ? HALF_DOUBLE : HALF_NORMAL;
    endfunction

endpackage

// File: verilog/baud_tick_gen.sv
// oversampling tick generator, period divisor+1 clocks
module baud_tick_gen
    import uart_mp_pkg::*;
(
    input  wire logic             clk,      // system clock
    input  wire logic             reset_n,  // synchronous reset, low
    input  wire logic [DIV_W-1:0] divisor,  // baud_divisor
    output logic                  tick      // one-cycle oversample pulse
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } tick_state_t;

    tick_state_t s_q;
    tick_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        // zero divisor ticks every clock: fastest rate
        if (s_q.cnt >= divisor) begin
            s_d.cnt = DIV_RESET;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 12'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule

// File: verilog/uart_multidrop_address_filter.sv
// serial port with multi-drop address filter and apb register access
module uart_multidrop_address_filter
    import uart_mp_pkg::*;
(
    input  wire logic              clk,      // system clock, 50 MHz
    input  wire logic              reset_n,  // synchronous reset, low
    input  wire logic              psel,     // apb select
    input  wire logic              penable,  // apb access phase
    input  wire logic              pwrite,   // apb direction, high write
    input  wire logic [ADDR_W-1:0] paddr,    // apb byte address
    input  wire logic [31:0]       pwdata,   // apb write data
    output logic      [31:0]       prdata,   // apb read data
    output logic                   pready,   // apb ready
    output logic                   pslverr,  // apb error, unmapped address
    input  wire logic              rxd,      // serial receive line
    output logic                   txd,      // serial transmit line
    output logic                   irq       // level interrupt
);

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [DIV_W-1:0]  divisor;
        logic [EV_W-1:0]   intMask;
        logic [EV_W-1:0]   intStatus;
        logic              rxComplete;
        logic              txComplete;
        logic              frameErr;
        logic              rxNinth;
        logic [7:0]        rxBuf;
        rx_state_t         rxState;
        logic [3:0]        rxCnt;
        logic [3:0]        rxBit;
        logic [8:0]        rxShift;
        tx_state_t         txState;
        logic [3:0]        txCnt;
        logic [3:0]        txBit;
        logic [8:0]        txShift;
        logic              txStop2nd;
        logic              txLine;
        logic [31:0]       rdata;
        logic              slvErr;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic tick;

    baud_tick_gen u_tick (
        .clk     (clk),
        .reset_n (reset_n),
        .divisor (s_q.divisor),
        .tick    (tick)
    );

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        return a == ADDR_CTRL || a == ADDR_STATUS || a == ADDR_DATA ||
               a == ADDR_BAUD || a == ADDR_INT_STAT || a == ADDR_INT_MASK;
    endfunction

    // drop the unused low positions of a short character
    function automatic logic [7:0] rxAlign(input logic [8:0] sh, input logic [3:0] n);
        logic [8:0] v;
        v = sh >> (BITS_NINE - n);
        return v[7:0];
    endfunction

    logic       setupPh;
    logic       accessPh;
    logic       wrAcc;
    logic       rdAcc;
    logic [2:0] charSize;
    logic [3:0] nBits;
    logic       dbl;
    logic [EV_W-1:0] events;
    logic       frameType;

    // one setting for both directions
    assign charSize = s_q.ctrl[CTRL_SIZE_LSB +: 3];
    assign nBits    = dataBits(charSize);
    assign dbl      = s_q.ctrl[CTRL_DOUBLE];
    assign setupPh  = psel & ~penable;
    assign accessPh = psel & penable;
    assign wrAcc    = accessPh & pwrite & isMapped(paddr);
    assign rdAcc    = accessPh & ~pwrite & isMapped(paddr);

    always_comb begin
        s_d = s_q;
        events = EV_NONE;
        frameType = 1'b0;

        // ---------------- bus: read data prepared in setup phase
        if (setupPh) begin
            s_d.rdata = 32'h0000_0000;
            s_d.slvErr = ~isMapped(paddr);
            case (paddr)
                ADDR_CTRL:     s_d.rdata[CTRL_W-1:0] = s_q.ctrl;
                ADDR_STATUS: begin
                    s_d.rdata[ST_RXC]    = s_q.rxComplete;
                    s_d.rdata[ST_TXC]    = s_q.txComplete;
                    s_d.rdata[ST_FE]     = s_q.frameErr;
                    s_d.rdata[ST_RX9]    = s_q.rxNinth;
                    s_d.rdata[ST_TXBUSY] = (s_q.txState != TX_IDLE);
                end
                ADDR_DATA:     s_d.rdata[7:0] = s_q.rxBuf;
                ADDR_BAUD:     s_d.rdata[DIV_W-1:0] = s_q.divisor;
                ADDR_INT_STAT: s_d.rdata[EV_W-1:0] = s_q.intStatus;
                ADDR_INT_MASK: s_d.rdata[EV_W-1:0] = s_q.intMask;
                default:       s_d.rdata = 32'h0000_0000;
            endcase
        end

        // ---------------- bus: writes and clearing side effects
        // control write leaves tx_complete_flag alone, it lives in status
        if (wrAcc) begin
            case (paddr)
                ADDR_CTRL:     s_d.ctrl = pwdata[CTRL_W-1:0];
                ADDR_STATUS: begin
                    if (pwdata[ST_TXC]) begin
                        s_d.txComplete = 1'b0;
                    end
                end
                ADDR_BAUD:     s_d.divisor = pwdata[DIV_W-1:0];
                ADDR_INT_MASK: s_d.intMask = pwdata[EV_W-1:0];
                default: ;
            endcase
        end
        if (rdAcc && paddr == ADDR_DATA) begin
            s_d.rxComplete = 1'b0;
        end
        if (rdAcc && paddr == ADDR_INT_STAT) begin
            s_d.intStatus = s_q.intStatus & ~s_q.rdata[EV_W-1:0];
        end

        // ---------------- receiver
        if (!s_q.ctrl[CTRL_RXEN]) begin
            s_d.rxState = RX_IDLE;
        end else begin
            case (s_q.rxState)
                RX_IDLE: begin
                    s_d.rxCnt = 4'h0;
                    if (!rxd) begin
                        s_d.rxState = RX_START;
                    end
                end
                RX_START: begin
                    if (tick) begin
                        s_d.rxCnt = s_q.rxCnt + 4'h1;
                        if (s_q.rxCnt == halfTick(dbl)) begin
                            // glitch shorter than half a bit is not a start
                            s_d.rxCnt = 4'h0;
                            s_d.rxBit = 4'h0;
                            s_d.rxState = rxd ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (tick) begin
                        s_d.rxCnt = s_q.rxCnt + 4'h1;
                        if (s_q.rxCnt == lastTick(dbl)) begin
                            s_d.rxCnt = 4'h0;
                            s_d.rxShift = {rxd, s_q.rxShift[8:1]};
                            s_d.rxBit = s_q.rxBit + 4'h1;
                            if (s_q.rxBit == nBits - 4'h1) begin
                                s_d.rxState = RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (tick) begin
                        s_d.rxCnt = s_q.rxCnt + 4'h1;
                        if (s_q.rxCnt == lastTick(dbl)) begin
                            s_d.rxState = RX_IDLE;
                            if (charSize == SIZE_NINE) begin
                                frameType = s_q.rxShift[8];
                            end else begin
                                frameType = rxd;
                            end
                            // type one marks an address frame
                            if (!s_q.ctrl[CTRL_FILTER] || frameType) begin
                                s_d.rxBuf = rxAlign(s_q.rxShift, nBits);
                                s_d.rxNinth = (charSize == SIZE_NINE) & s_q.rxShift[8];
                                s_d.frameErr = ~rxd;
                                s_d.rxComplete = 1'b1;
                                events[EV_RXC] = 1'b1;
                                events[EV_FE] = ~rxd;
                            end
                            // a dropped frame leaves buffer and flags as they were
                        end
                    end
                end
                default: s_d.rxState = RX_IDLE;
            endcase
        end

        // transmitter, independent of the filter enable
        // a data write while busy is ignored: no holding register
        case (s_q.txState)
            TX_IDLE: begin
                s_d.txLine = 1'b1;
                if (wrAcc && paddr == ADDR_DATA && s_q.ctrl[CTRL_TXEN]) begin
                    s_d.txShift = {s_q.ctrl[CTRL_TX9], pwdata[7:0]};
                    s_d.txCnt = 4'h0;
                    s_d.txLine = 1'b0;
                    s_d.txState = TX_START;
                end
            end
            TX_START: begin
                if (tick) begin
                    s_d.txCnt = s_q.txCnt + 4'h1;
                    if (s_q.txCnt == lastTick(dbl)) begin
                        s_d.txCnt = 4'h0;
                        s_d.txBit = 4'h0;
                        s_d.txLine = s_q.txShift[0];
                        s_d.txState = TX_DATA;
                    end
                end
            end
            TX_DATA: begin
                if (tick) begin
                    s_d.txCnt = s_q.txCnt + 4'h1;
                    if (s_q.txCnt == lastTick(dbl)) begin
                        s_d.txCnt = 4'h0;
                        s_d.txShift = {1'b0, s_q.txShift[8:1]};
                        s_d.txBit = s_q.txBit + 4'h1;
                        if (s_q.txBit == nBits - 4'h1) begin
                            s_d.txLine = 1'b1;
                            s_d.txStop2nd = 1'b0;
                            s_d.txState = TX_STOP;
                        end else begin
                            s_d.txLine = s_q.txShift[1];
                        end
                    end
                end
            end
            TX_STOP: begin
                if (tick) begin
                    s_d.txCnt = s_q.txCnt + 4'h1;
                    if (s_q.txCnt == lastTick(dbl)) begin
                        s_d.txCnt = 4'h0;
                        if (s_q.ctrl[CTRL_STOP2] && !s_q.txStop2nd) begin
                            s_d.txStop2nd = 1'b1;
                        end else begin
                            s_d.txState = TX_IDLE;
                            s_d.txComplete = 1'b1;
                            events[EV_TXC] = 1'b1;
                        end
                    end
                end
            end
            default: s_d.txState = TX_IDLE;
        endcase

        // sticky events, set beats a same-cycle read clear
        s_d.intStatus = s_d.intStatus | events;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.ctrl <= CTRL_RESET;
            s_q.divisor <= DIV_RESET;
            s_q.rxState <= RX_IDLE;
            s_q.txState <= TX_IDLE;
            s_q.txLine <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata  = s_q.rdata;
    assign pready  = 1'b1;
    assign pslverr = accessPh & s_q.slvErr;
    assign txd     = s_q.txLine;
    assign irq     = |(s_q.intStatus & s_q.intMask);

endmodule

// File: dv/uart_mp_properties.sv
// concurrent checks on the ports of the multi-drop serial port
module uart_mp_properties
    import uart_mp_pkg::*;
(
    input wire logic              clk,      // system clock
    input wire logic              reset_n,  // sync reset, low
    input wire logic              psel,     // apb select
    input wire logic              penable,  // apb access
    input wire logic              pwrite,   // apb direction
    input wire logic [ADDR_W-1:0] paddr,    // apb address
    input wire logic [31:0]       pwdata,   // apb write data
    input wire logic [31:0]       prdata,   // apb read data
    input wire logic              pready,   // apb ready
    input wire logic              pslverr,  // apb error
    input wire logic              rxd,      // serial in
    input wire logic              txd,      // serial out
    input wire logic              irq       // interrupt
);
    logic [CTRL_W-1:0] ctrlQ;
    logic [DIV_W-1:0]  divQ;
    logic [EV_W-1:0]   maskQ;
    logic [7:0]        highQ;
    logic              acc;
    logic              txGo;
    assign acc = psel && penable;
    // idle guard: 200 high clocks outlast any divisor-zero frame of ones
    assign txGo = acc && pwrite && paddr == ADDR_DATA && ctrlQ[CTRL_TXEN]
                  && divQ == DIV_RESET && highQ > 8'hc8 && pwdata[0];
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrlQ <= CTRL_RESET;
            divQ  <= DIV_RESET;
            maskQ <= EV_NONE;
            highQ <= 8'h00;
        end else begin
            highQ <= txd ? highQ + {7'h00, highQ != 8'hff} : 8'h00;
            if (acc && pwrite && paddr == ADDR_CTRL) ctrlQ <= pwdata[CTRL_W-1:0];
            if (acc && pwrite && paddr == ADDR_BAUD) divQ <= pwdata[DIV_W-1:0];
            if (acc && pwrite && paddr == ADDR_INT_MASK) maskQ <= pwdata[EV_W-1:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_ready_always: assert property (pready) else $error("pready low");
    a_unmapped_err: assert property (acc && paddr > ADDR_INT_MASK
        |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc && paddr <= ADDR_INT_MASK && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("mapped access refused");
    a_err_idle: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
    a_mask_gates_irq: assert property ($past(maskQ) == EV_NONE && maskQ == EV_NONE |-> !irq)
        else $error("irq with all events masked");
    a_irq_sticky: assert property (irq && !(acc && (paddr == ADDR_INT_STAT
        || paddr == ADDR_INT_MASK)) |=> irq) else $error("irq dropped without clear");
    a_tx_start_normal: assert property (txGo && !ctrlQ[CTRL_DOUBLE] |=> !txd ##16 txd)
        else $error("normal start bit length wrong");
    a_tx_start_double: assert property (txGo && ctrlQ[CTRL_DOUBLE] |=> !txd ##8 txd)
        else $error("double speed start bit length wrong");
    a_kept_on_type: assert property ($rose(irq) && maskQ == 3'h1 && $past(maskQ) == 3'h1
        && ctrlQ[CTRL_FILTER] && ctrlQ[3:1] != SIZE_NINE |-> rxd)
        else $error("short frame kept with type bit low");
    c_tx: cover property (txGo);
    c_irq: cover property ($rose(irq));
    c_err: cover property (acc && pslverr);
endmodule

bind uart_multidrop_address_filter uart_mp_properties uart_mp_properties_inst (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .irq(irq));

// File: dv/serial_master.sv
// bus master on the shared serial line, sending at divisor zero
module serial_master
(
    input  wire logic clk,  // system clock
    output logic      line  // serial line, idles high
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line = 1'b1;
    // sixteen clocks a bit; nine-bit frames carry the type as bit eight
    task automatic send(input logic [8:0] d, input int n, input logic typ);
        line <= 1'b0;
        repeat (16) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            line <= (i == 8) ? typ : d[i];
            repeat (16) @(posedge clk);
        end
        if (n < 9) begin
            line <= typ;
            repeat (16) @(posedge clk);
        end
        line <= 1'b1;
        repeat (32) @(posedge clk);
    endtask
endmodule

// File: dv/tb_top.sv
// self-checking bench for the multi-drop serial port with address filter
module tb_top
    import uart_mp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r, lastData;
    logic        pready, pslverr, txd, irq, e;
    wire logic   rxd;
    logic [31:0] seed = 32'hccfd6401;
    int          mismatches = 0;
    int          nTests = 0;
    int          cycles = 0;

    uart_multidrop_address_filter uart_multidrop_address_filter_inst (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
    serial_master serial_master_inst (.clk(clk), .line(rxd));

    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            wrapUp();
        end
    end

    task automatic wrapUp();
        if (mismatches == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // one idle clock after each transfer keeps strobes from being set twice at once
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rxFrame(input logic [8:0] d, input logic [2:0] s, input logic f,
                           input logic t);
        int   n;
        logic k;
        n = (s == SIZE_NINE) ? 9 : 5 + int'(s[1:0]);
        k = !f || t;
        apb(ADDR_CTRL, 1'b1, {23'h0, 1'b1, 1'b1, 3'h0, s, f});
        serial_master_inst.send(d, n, t);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check(r[0], k);
        if (k) begin
            lastData = {24'h0, d[7:0] & 8'((1 << n) - 1)};
            check(r[3], n == 9 && t);
            check(r[2], n < 9 && !t);
        end
        check(irq, k);
        apb(ADDR_INT_STAT, 1'b0, 32'h0);
        check(r[0], k);
        check(irq, 1'b0);
        apb(ADDR_DATA, 1'b0, 32'h0);
        check(r[7:0], lastData[7:0]);
    endtask

    task automatic txFrame(input logic [2:0] s, input logic dbl, input logic f,
                           input logic [8:0] d);
        int          n;
        int          len;
        logic [10:0] fr;
        n = (s == SIZE_NINE) ? 9 : 5 + int'(s[1:0]);
        len = dbl ? 8 : 16;
        fr = (11'h7ff << (n + 1)) | ({1'b0, d, 1'b0} & ~(11'h7ff << (n + 1)));
        // filtered runs also use two stop bits, so the second-stop path is reached
        apb(ADDR_CTRL, 1'b1, {23'h0, 1'b1, 1'b1, d[8], dbl, f, s, f});
        repeat (220) @(posedge clk);
        apb(ADDR_DATA, 1'b1, {23'h0, d});
        repeat (len / 2 - 1) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            #1;
            check(txd, fr[i]);
            repeat (len) @(posedge clk);
        end
        // a second stop bit may still be on the line
        repeat (len) @(posedge clk);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check(r[1], 1'b1);
        apb(ADDR_STATUS, 1'b1, 32'h2);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        check(txd, 1'b1);
        check(irq, 1'b0);
        apb(ADDR_CTRL, 1'b0, 32'h0);
        check(r, {23'h0, CTRL_RESET});
        apb(ADDR_BAUD, 1'b0, 32'h0);
        check(r, 32'h0);
        apb(8'h18, 1'b0, 32'h0);
        check({r, e}, {32'h0, 1'b1});
        apb(8'h3c, 1'b1, 32'h5a);
        check(e, 1'b1);
        apb(ADDR_INT_MASK, 1'b1, 32'h1);
        lastData = 32'h0;
        rxFrame(9'h055, SIZE_NINE, 1'b1, 1'b0);
        rxFrame(9'h1a3, SIZE_NINE, 1'b1, 1'b1);
        // addressed slave opens its filter
        rxFrame(9'h03c, SIZE_NINE, 1'b0, 1'b0);
        rxFrame(9'h0c1, SIZE_NINE, 1'b0, 1'b0);
        // last data seen, filter closes again
        rxFrame(9'h07e, SIZE_NINE, 1'b1, 1'b0);
        repeat (12) begin
            seed = lfsr(seed);
            rxFrame(seed[8:0], SIZE_NINE, seed[9], seed[8]);
        end
        for (int s = 0; s < 4; s++) begin
            seed = lfsr(seed);
            rxFrame(seed[8:0], 3'(s), 1'b1, 1'b0);
            rxFrame(seed[8:0], 3'(s), 1'b1, 1'b1);
        end
        rxFrame(9'h0a6, 3'h3, 1'b0, 1'b0);
        for (int s = 0; s < 5; s++) begin
            seed = lfsr(seed);
            txFrame(s == 4 ? SIZE_NINE : 3'(s), s[0], s[1], seed[8:0] | 9'h001);
        end
        wrapUp();
    end
endmodule
